/* rtl/fcs_pkg.sv */
package fcs_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [3:0] ADDR_STATUS = 4'h0;
	localparam logic [3:0] ADDR_MASK   = 4'h4;
	localparam logic [3:0] ADDR_CHIP   = 4'h8;

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int         BIT_ERASE   = 0;
	localparam int         BIT_WRITE   = 1;
	localparam int         IRQ_W       = 2;
	localparam int         CHIP_W      = 3;
	localparam logic [1:0] MASK_RST    = 2'h0;
	localparam logic [1:0] STATUS_RST  = 2'h0;
	localparam logic [2:0] CHIP_RST    = 3'h0;
	localparam logic [2:0] CHIP_ONE    = 3'h1;
	localparam logic [2:0] CHIP_TWO    = 3'h2;
	localparam logic [2:0] CHIP_THREE  = 3'h4;

	// ----------------------------------------------------------------
	// Bus answers and types
	// ----------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic write_cancel;
		logic erase_cancel;
	} fcs_event_t;

	typedef enum logic [1:0] {
		FCS_CHIP1 = 2'b00,
		FCS_CHIP2 = 2'b01,
		FCS_CHIP3 = 2'b10
	} fcs_chip_t;

endpackage

/* rtl/fcs_irq.sv */
`timescale 1ns/100ps
`default_nettype none
module fcs_irq
	import fcs_pkg::*;
(
	// Clock and reset
	input  wire logic             aclk,
	input  wire logic             aresetn,
	// Events and software access
	input  wire fcs_event_t       events,
	input  wire logic             clr_en,
	input  wire logic [IRQ_W-1:0] clr_bits,
	input  wire logic [IRQ_W-1:0] mask,
	// State
	output logic      [IRQ_W-1:0] status_q,
	output logic                  irq_q
);

	logic [IRQ_W-1:0] set_bits;
	logic [IRQ_W-1:0] status_d;

	always_comb begin
		set_bits            = '0;
		set_bits[BIT_WRITE] = events.write_cancel;
		set_bits[BIT_ERASE] = events.erase_cancel;
		status_d            = status_q;
		if (clr_en) begin
			status_d = status_q & ~clr_bits;
		end
		status_d = status_d | set_bits;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			status_q <= STATUS_RST;
		end else begin
			status_q <= status_d;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(status_d & mask);
		end
	end

	set_wins_a: assert property (@(posedge aclk) disable iff (!aresetn)
		events.write_cancel |=> status_q[BIT_WRITE])
		else $error("write cancel did not set status");
	erase_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
		events.erase_cancel |=> status_q[BIT_ERASE])
		else $error("erase cancel did not set status");
	irq_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
		##1 (irq_q == |(status_q & $past(mask))))
		else $error("interrupt level disagrees with status and mask");

endmodule
`default_nettype wire

/* rtl/fcs_regs.sv */
// How it works
// - Mask bit 1 enables the illegal-write interrupt; resets to 0.
// - Mask bit 0 enables the illegal-erase interrupt; resets to 0.
// - Chip-select value with only bit 2 set selects the third chip.
// - Chip-select value with only bit 1 set selects the second chip.
// - Bits 2 and 1 zero select the first chip; reset selects it.
// - Cancelled protected write sets status bit 1; writing 1 clears it.
// - Cancelled protected erase sets status bit 0; writing 1 clears it.
`timescale 1ns/100ps
`default_nettype none
module fcs_regs
	import fcs_pkg::*;
(
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite write address
	input  wire logic [3:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [3:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Flash controller events
	input  wire logic        write_cancel,
	input  wire logic        erase_cancel,
	// Chip select to the flash side, and the interrupt
	output logic [CHIP_W-1:0] chip_sel_q,
	output logic             irq
);

	// ----------------------------------------------------------------
	// Write channel capture
	// ----------------------------------------------------------------
	logic [3:0]        aw_addr_q;
	logic              aw_have_q;
	logic [31:0]       w_data_q;
	logic [3:0]        w_strb_q;
	logic              w_have_q;
	logic              wr_go;
	logic [IRQ_W-1:0]  mask_q;
	logic [IRQ_W-1:0]  status;
	logic [CHIP_W-1:0] chip_raw_q;
	fcs_event_t        ev;

	assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q     <= 1'b0;
			aw_addr_q     <= 4'h0;
			s_axi_awready <= 1'b0;
		end else begin
			s_axi_awready <= !aw_have_q && !s_axi_awready && s_axi_awvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end else if (wr_go) begin
				aw_have_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_have_q     <= 1'b0;
			w_data_q     <= 32'h0;
			w_strb_q     <= 4'h0;
			s_axi_wready <= 1'b0;
		end else begin
			s_axi_wready <= !w_have_q && !s_axi_wready && s_axi_wvalid;
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end else if (wr_go) begin
				w_have_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (aw_addr_q == ADDR_STATUS || aw_addr_q == ADDR_MASK ||
				aw_addr_q == ADDR_CHIP) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Mask and chip-select registers
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mask_q <= MASK_RST;
		end else if (wr_go && aw_addr_q == ADDR_MASK && w_strb_q[0]) begin
			mask_q[BIT_WRITE] <= w_data_q[BIT_WRITE];
			mask_q[BIT_ERASE] <= w_data_q[BIT_ERASE];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			chip_raw_q <= CHIP_RST;
		end else if (wr_go && aw_addr_q == ADDR_CHIP && w_strb_q[0]) begin
			chip_raw_q <= w_data_q[CHIP_W-1:0];
		end
	end

	// Decode written value to one-hot chip select
	function automatic logic [CHIP_W-1:0] chip_decode(input logic [CHIP_W-1:0] v);
		if (v == CHIP_THREE) begin
			return CHIP_THREE;
		end else if (v == CHIP_TWO) begin
			return CHIP_TWO;
		end else begin
			return CHIP_ONE;
		end
	endfunction

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			chip_sel_q <= CHIP_ONE;
		end else begin
			chip_sel_q <= chip_decode(chip_raw_q);
		end
	end

	// ----------------------------------------------------------------
	// Interrupt status
	// ----------------------------------------------------------------
	assign ev = '{write_cancel: write_cancel, erase_cancel: erase_cancel};

	fcs_irq u_irq (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.events   (ev),
		.clr_en   (wr_go && aw_addr_q == ADDR_STATUS && w_strb_q[0]),
		.clr_bits (w_data_q[IRQ_W-1:0]),
		.mask     (mask_q),
		.status_q (status),
		.irq_q    (irq)
	);

	// ----------------------------------------------------------------
	// Read channel
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= RESP_OKAY;
				s_axi_rdata  <= 32'h0;
				unique case (s_axi_araddr)
					ADDR_STATUS: s_axi_rdata[IRQ_W-1:0] <= status;
					ADDR_MASK:   s_axi_rdata[IRQ_W-1:0] <= mask_q;
					ADDR_CHIP:   s_axi_rdata[CHIP_W-1:0] <= chip_sel_q;
					default:     s_axi_rresp <= RESP_SLVERR;
				endcase
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	sequence mask_wr_s;
		wr_go && aw_addr_q == ADDR_MASK && w_strb_q[0];
	endsequence

	mask_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
		mask_wr_s |=> mask_q[BIT_WRITE] == $past(w_data_q[BIT_WRITE]))
		else $error("write mask bit not stored");
	mask_erase_a: assert property (@(posedge aclk) disable iff (!aresetn)
		mask_wr_s |=> mask_q[BIT_ERASE] == $past(w_data_q[BIT_ERASE]))
		else $error("erase mask bit not stored");
	chip_three_a: assert property (@(posedge aclk) disable iff (!aresetn)
		chip_raw_q == CHIP_THREE |=> chip_sel_q == CHIP_THREE)
		else $error("third chip not selected");
	chip_two_a: assert property (@(posedge aclk) disable iff (!aresetn)
		chip_raw_q == CHIP_TWO |=> chip_sel_q == CHIP_TWO)
		else $error("second chip not selected");
	chip_one_a: assert property (@(posedge aclk) disable iff (!aresetn)
		chip_raw_q[2:1] == 2'h0 |=> chip_sel_q == CHIP_ONE)
		else $error("first chip not selected");
	status_clr_a: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_go && aw_addr_q == ADDR_STATUS && w_strb_q[0] && w_data_q[BIT_WRITE]
		&& !write_cancel |=> !status[BIT_WRITE])
		else $error("write status not cleared");
	erase_clr_a: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_go && aw_addr_q == ADDR_STATUS && w_strb_q[0] && w_data_q[BIT_ERASE]
		&& !erase_cancel |=> !status[BIT_ERASE])
		else $error("erase status not cleared");
	irq_masked_a: assert property (@(posedge aclk) disable iff (!aresetn)
		mask_q == 2'h0 [*2] |-> !irq)
		else $error("interrupt raised while fully masked");

endmodule
`default_nettype wire

/* bench/fcs_flash_model.sv */
`timescale 1ns/100ps
`default_nettype none
module fcs_flash_model
	import fcs_pkg::*;
(
	// Clock
	input  wire logic              aclk,
	// Select from the block, cancel commands from the bench
	input  wire logic [CHIP_W-1:0] chip_sel,
	input  wire logic [1:0]        cancel_cmd,
	// Cancel events towards the block, chip number towards the bench
	output logic                   write_cancel = 1'b0,
	output logic                   erase_cancel = 1'b0,
	output logic [1:0]             chip_num
);
	// Addressed chip
	always_comb begin
		case (chip_sel)
			CHIP_THREE: chip_num = 2'h2;
			CHIP_TWO:   chip_num = 2'h1;
			default:    chip_num = 2'h0;
		endcase
	end
	// Cancelled protected operations as one-cycle pulses
	always @(posedge aclk) begin
		write_cancel <= cancel_cmd[1];
		erase_cancel <= cancel_cmd[0];
	end
endmodule
`default_nettype wire

/* bench/tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb;
	import fcs_pkg::*;
	logic              aclk = 1'b0;
	logic              aresetn = 1'b0;
	logic [3:0]        awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
	logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic              arvalid = 1'b0, rready = 1'b0;
	logic [31:0]       wdata = 32'h0, rdata, seed = 32'hc6bc;
	logic              awready, wready, bvalid, arready, rvalid, irq, wc, ec;
	logic [1:0]        bresp, rresp, chip_num, cmd = 2'h0;
	logic [CHIP_W-1:0] chip_sel_q;
	int                fail_count = 0, compares = 0;
	logic [3:0]        wr_strb = 4'hf;

	always #25 aclk = ~aclk;

	fcs_regs fcs_regs_inst (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.write_cancel(wc), .erase_cancel(ec), .chip_sel_q(chip_sel_q), .irq(irq));
	fcs_flash_model fcs_flash_model_inst (.aclk(aclk), .chip_sel(chip_sel_q), .cancel_cmd(cmd),
		.write_cancel(wc), .erase_cancel(ec), .chip_num(chip_num));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [31:0] exp_chip(input logic [2:0] v);
		return (v == 3'h4) ? 32'h4 : (v == 3'h2) ? 32'h2 : 32'h1;
	endfunction
	task automatic report_and_stop();
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic tick(inout int n);
		@(posedge aclk);
		n++;
		if (n > 200) begin
			fail_count++;
			report_and_stop();
		end
	endtask
	task automatic axi_write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		logic aw_ok, w_ok;
		n = 0;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wstrb <= wr_strb;
		wvalid <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			tick(n);
			if (!aw_ok && awready === 1'b1) begin
				aw_ok = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_ok && wready === 1'b1) begin
				w_ok = 1'b1;
				wvalid <= 1'b0;
			end
		end
		bready <= 1'b1;
		do tick(n); while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask
	task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		do tick(n); while (arready !== 1'b1);
		arvalid <= 1'b0;
		rready <= 1'b1;
		do tick(n); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask

	// ------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------
	initial begin
		logic [31:0] d;
		logic [1:0]  r;
		logic [2:0]  v;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		check("chip pin", 32'(chip_sel_q), 32'h1);
		axi_read(ADDR_MASK, d, r);
		check("mask reset", d, 32'h0);
		check("mask resp", 32'(r), 32'(RESP_OKAY));
		axi_read(4'hc, d, r);
		check("unmapped resp", 32'(r), 32'(RESP_SLVERR));
		$display("test reset done");
		for (int i = 0; i < 16; i++) begin
			v = (i < 8) ? 3'(i) : 3'(rnd());
			axi_write(ADDR_CHIP, {29'h0, v}, r);
			check("chip resp", 32'(r), 32'(RESP_OKAY));
			repeat (2) @(posedge aclk);
			check("chip pin", 32'(chip_sel_q), exp_chip(v));
			check("chip num", 32'(chip_num), exp_chip(v) >> 1);
			axi_read(ADDR_CHIP, d, r);
			check("chip read", d, exp_chip(v));
		end
		$display("test chip select done");
		for (int m = 0; m < 4; m++) begin
			for (int e = 1; e < 4; e++) begin
				axi_write(ADDR_MASK, 32'(m), r);
				axi_read(ADDR_MASK, d, r);
				check("mask", d, 32'(m));
				cmd <= 2'(e);
				@(posedge aclk);
				cmd <= 2'h0;
				repeat (3) @(posedge aclk);
				check("irq set", 32'(irq), 32'((m & e) != 0));
				axi_read(ADDR_STATUS, d, r);
				check("status", d, 32'(e));
				axi_write(ADDR_STATUS, 32'(e), r);
				@(posedge aclk);
				check("irq clear", 32'(irq), 32'h0);
				axi_read(ADDR_STATUS, d, r);
				check("status clear", d, 32'h0);
			end
		end
		$display("test interrupt done");
		// Event and clear land on one edge: the event wins
		fork
			axi_write(ADDR_STATUS, 32'h2, r);
			begin
				@(posedge aclk);
				cmd <= 2'h2;
				@(posedge aclk);
				cmd <= 2'h0;
			end
		join
		axi_read(ADDR_STATUS, d, r);
		check("set wins", d, 32'h2);
		check("irq set wins", 32'(irq), 32'h1);
		wr_strb = 4'he;
		axi_write(ADDR_MASK, 32'h0, r);
		wr_strb = 4'hf;
		axi_read(ADDR_MASK, d, r);
		check("mask strobe", d, 32'h3);
		axi_write(4'hc, 32'h0, r);
		check("unmapped write", 32'(r), 32'(RESP_SLVERR));
		$display("test corner cases done");
		axi_write(ADDR_CHIP, 32'h4, r);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		check("irq after reset", 32'(irq), 32'h0);
		check("chip after reset", 32'(chip_sel_q), 32'h1);
		axi_read(ADDR_MASK, d, r);
		check("mask after reset", d, 32'h0);
		axi_read(ADDR_STATUS, d, r);
		check("status after reset", d, 32'h0);
		$display("test mid reset done");
		report_and_stop();
	end
endmodule
`default_nettype wire
